//--- include/dpm_params.svh
// Constants for the diagnostic probe pin multiplexer.
// Assumes it is included by the package and the design file only.
`ifndef DPM_PARAMS_SVH
`define DPM_PARAMS_SVH

// Positions of the multifunction pins in the four-pin group.
`define DPM_IDX_DIAG_CLOCK_PIN     0
`define DPM_IDX_SDI      1
`define DPM_IDX_PRA      2
`define DPM_IDX_PRB      3
`define DPM_MF_PINS      4

// Default sizes of the user pad group and the node space.
`define DPM_IO_PINS_DEF  8
`define DPM_NODES_DEF    16

// Reset values.
`define DPM_LOCK_RST     1'h0
`define DPM_LEVEL_RST    1'h0

`endif

//--- include/dpm_pkg.sv
// Types shared by the diagnostic probe pin multiplexer and its bench.
// Assumes dpm_params.svh sits on the include path.
`include "dpm_params.svh"

package dpm_pkg;

  // Pad buffer configuration for every user-usable pin.
  typedef enum logic [1:0] {
    PAD_INPUT  = 2'h0,
    PAD_OUTPUT = 2'h1,
    PAD_TRI    = 2'h2,
    PAD_BIDIR  = 2'h3
  } dpm_pad_cfg_t;

  // User-side control of one pad.
  typedef struct packed {
    dpm_pad_cfg_t cfg;
    logic         dout;
    logic         oe_req;
  } dpm_pad_ctl_t;

endpackage

//--- design/dpm_pin_mux.sv
// Pin multiplexer for multifunction diagnostic pins, user pads and the global clock pad.
// Assumes all pad inputs are asynchronous to ref_clk and node_in is on ref_clk.
`include "dpm_params.svh"

module dpm_pin_mux
  import dpm_pkg::*;
#(
  parameter int unsigned IO_PINS = `DPM_IO_PINS_DEF,
  parameter int unsigned NODES   = `DPM_NODES_DEF
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  // Mode pin, pulled low outside
  input  wire logic                  mode_pin,
  // Multifunction pins
  input  wire logic [`DPM_MF_PINS-1:0] mf_pin_i,
  output logic      [`DPM_MF_PINS-1:0] mf_pin_o,
  output logic      [`DPM_MF_PINS-1:0] mf_pin_oe,
  // User pads
  input  wire logic [IO_PINS-1:0]    io_pin_i,
  output logic      [IO_PINS-1:0]    io_pin_o,
  output logic      [IO_PINS-1:0]    io_pin_oe,
  // Global clock pad
  input  wire logic                  gclk_pin_i,
  output logic                       gclk_pin_o,
  output logic                       gclk_pin_oe,
  // User logic side
  input  dpm_pad_ctl_t [`DPM_MF_PINS-1:0] mf_ctl,
  output logic      [`DPM_MF_PINS-1:0] mf_user_in,
  input  dpm_pad_ctl_t [IO_PINS-1:0] io_ctl,
  output logic      [IO_PINS-1:0]    io_user_in,
  input  wire logic                  gclk_as_io,
  input  dpm_pad_ctl_t               gclk_ctl,
  output logic                       gclk_user_in,
  output logic                       gclk_buf,
  // Probe sources and protection
  input  wire logic [NODES-1:0]      node_in,
  input  wire logic                  probe_fuse,
  // Status
  output logic                       probe_locked,
  output logic                       diag_active
);

  localparam int unsigned SELW  = (NODES > 1) ? $clog2(NODES) : 1;
  localparam int unsigned FRAME = 2 * SELW + 1;
  localparam int unsigned CNTW  = $clog2(FRAME + 1);

  // Refused at elaboration: a single node leaves no select field to shift in.
  if (NODES < 2 || IO_PINS < 1) begin : g_bad_size
    $error("dpm_pin_mux: NODES must be at least 2 and IO_PINS at least 1");
  end

  // Output enable that a pad configuration asks for.
  function automatic logic pad_oe(input dpm_pad_ctl_t ctl);
    logic oe;
    oe = 1'b0;
    unique case (ctl.cfg)
      PAD_INPUT:  oe = 1'b0;
      PAD_OUTPUT: oe = 1'b1;
      PAD_TRI:    oe = ctl.oe_req;
      PAD_BIDIR:  oe = ctl.oe_req;
    endcase
    return oe;
  endfunction

  // Two-flop synchronisers; only the second stage is read.
  logic                    mode_s1_q,  mode_s2_q;
  logic [`DPM_MF_PINS-1:0] mf_s1_q,    mf_s2_q;
  logic [IO_PINS-1:0]      io_s1_q,    io_s2_q;
  logic                    gclk_s1_q,  gclk_s2_q;

  always_ff @(posedge ref_clk) begin
    mode_s1_q <= mode_pin;
    mode_s2_q <= mode_s1_q;
    mf_s1_q   <= mf_pin_i;
    mf_s2_q   <= mf_s1_q;
    io_s1_q   <= io_pin_i;
    io_s2_q   <= io_s1_q;
    gclk_s1_q <= gclk_pin_i;
    gclk_s2_q <= gclk_s1_q;
  end

  // Serial select frame: {lock, sel_b, sel_a}, shifted in MSB first on diag clock rises.
  logic             diag_clock_pin_prev_q;
  logic [FRAME-1:0] shift_q,  shift_d;
  logic [CNTW-1:0]  cnt_q,    cnt_d;
  logic [SELW-1:0]  sel_a_q,  sel_a_d;
  logic [SELW-1:0]  sel_b_q,  sel_b_d;
  logic             lock_q,   lock_d;

  wire special    = mode_s2_q;
  wire diag_clock_pin_rise  = special & mf_s2_q[`DPM_IDX_DIAG_CLOCK_PIN] & ~diag_clock_pin_prev_q;
  wire sdi_bit    = mf_s2_q[`DPM_IDX_SDI];
  wire frame_done = diag_clock_pin_rise && (cnt_q == CNTW'(FRAME - 1));
  wire probe_live = special & ~lock_q & ~probe_fuse;

  always_comb begin
    shift_d = shift_q;
    cnt_d   = cnt_q;
    sel_a_d = sel_a_q;
    sel_b_d = sel_b_q;
    lock_d  = lock_q | probe_fuse;
    if (!special) begin
      cnt_d = '0;
    end else if (diag_clock_pin_rise) begin
      shift_d = {shift_q[FRAME-2:0], sdi_bit};
      cnt_d   = frame_done ? '0 : cnt_q + CNTW'(1);
      if (frame_done) begin
        if (shift_d[FRAME-1]) begin
          lock_d = 1'b1;
        end else begin
          sel_a_d = shift_d[SELW-1:0];
          sel_b_d = shift_d[2*SELW-1:SELW];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      diag_clock_pin_prev_q <= `DPM_LEVEL_RST;
      shift_q     <= '0;
      cnt_q       <= '0;
      sel_a_q     <= '0;
      sel_b_q     <= '0;
      lock_q      <= `DPM_LOCK_RST;
    end else begin
      diag_clock_pin_prev_q <= mf_s2_q[`DPM_IDX_DIAG_CLOCK_PIN];
      shift_q     <= shift_d;
      cnt_q       <= cnt_d;
      sel_a_q     <= sel_a_d;
      sel_b_q     <= sel_b_d;
      lock_q      <= lock_d;
    end
  end

  // Pin drive selection.
  logic [`DPM_MF_PINS-1:0] mf_user_oe, mf_user_do, mf_o_d, mf_oe_d;
  logic [IO_PINS-1:0]      io_oe_d,    io_o_d;

  always_comb begin
    for (int i = 0; i < `DPM_MF_PINS; i++) begin
      mf_user_oe[i] = pad_oe(mf_ctl[i]);
      mf_user_do[i] = mf_ctl[i].dout;
    end
    for (int i = 0; i < IO_PINS; i++) begin
      io_oe_d[i] = pad_oe(io_ctl[i]);
      io_o_d[i]  = io_ctl[i].dout;
    end
  end

  wire probe_a = node_in[sel_a_q];
  wire probe_b = node_in[sel_b_q];

  // In special mode the clock and serial pins are inputs only; a locked probe pin floats.
  always_comb begin
    mf_o_d  = special ? '0 : mf_user_do;
    mf_oe_d = special ? '0 : mf_user_oe;
    mf_o_d[`DPM_IDX_PRA]  = special ? (probe_live & probe_a) : mf_user_do[`DPM_IDX_PRA];
    mf_o_d[`DPM_IDX_PRB]  = special ? (probe_live & probe_b) : mf_user_do[`DPM_IDX_PRB];
    mf_oe_d[`DPM_IDX_PRA] = special ? probe_live : mf_user_oe[`DPM_IDX_PRA];
    mf_oe_d[`DPM_IDX_PRB] = special ? probe_live : mf_user_oe[`DPM_IDX_PRB];
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mf_pin_o     <= '0;
      mf_pin_oe    <= '0;
      io_pin_o     <= '0;
      io_pin_oe    <= '0;
      gclk_pin_o   <= `DPM_LEVEL_RST;
      gclk_pin_oe  <= `DPM_LEVEL_RST;
      mf_user_in   <= '0;
      io_user_in   <= '0;
      gclk_user_in <= `DPM_LEVEL_RST;
      gclk_buf     <= `DPM_LEVEL_RST;
    end else begin
      mf_pin_o     <= mf_o_d;
      mf_pin_oe    <= mf_oe_d;
      io_pin_o     <= io_o_d;
      io_pin_oe    <= io_oe_d;
      gclk_pin_o   <= gclk_as_io & gclk_ctl.dout;
      gclk_pin_oe  <= gclk_as_io & pad_oe(gclk_ctl);
      mf_user_in   <= special ? '0 : mf_s2_q;
      io_user_in   <= io_s2_q;
      gclk_user_in <= gclk_as_io & gclk_s2_q;
      gclk_buf     <= ~gclk_as_io & gclk_s2_q;
    end
  end

  assign probe_locked = lock_q | probe_fuse;
  assign diag_active  = special;

  // Assertions. The mode pin reaches the pins three edges after it changes.
  AST_MODE_USER: assert property (@(posedge ref_clk) disable iff (srst)
    !special ##1 1 |-> mf_pin_oe == $past(mf_user_oe))
    else $error("user mode pad enables not passed through");
  AST_IN_ONLY: assert property (@(posedge ref_clk) disable iff (srst)
    special |=> !mf_pin_oe[`DPM_IDX_DIAG_CLOCK_PIN] && !mf_pin_oe[`DPM_IDX_SDI])
    else $error("diag clock or serial pin driven in special mode");
  AST_SEL_LOAD: assert property (@(posedge ref_clk) disable iff (srst)
    frame_done && !shift_d[FRAME-1] |=> sel_a_q == $past(shift_d[SELW-1:0]))
    else $error("probe select not loaded from serial frame");
  AST_PROBE_A: assert property (@(posedge ref_clk) disable iff (srst)
    probe_live |=> mf_pin_oe[`DPM_IDX_PRA] && mf_pin_o[`DPM_IDX_PRA] == $past(probe_a))
    else $error("first probe does not follow its node");
  AST_PROBE_B: assert property (@(posedge ref_clk) disable iff (srst)
    probe_live |=> mf_pin_oe[`DPM_IDX_PRB] && mf_pin_o[`DPM_IDX_PRB] == $past(node_in[sel_b_q]))
    else $error("second probe does not follow its node");
  AST_INDEP: assert property (@(posedge ref_clk) disable iff (srst)
    frame_done && !shift_d[FRAME-1] |=> sel_b_q == $past(shift_d[2*SELW-1:SELW]))
    else $error("second probe select not independent");
  AST_LOCK_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
    probe_locked |=> probe_locked [*8])
    else $error("probe lock released");
  AST_LOCK_DARK: assert property (@(posedge ref_clk) disable iff (srst)
    $past(probe_locked) && $past(special) |->
      !mf_pin_oe[`DPM_IDX_PRA] && !mf_pin_oe[`DPM_IDX_PRB] &&
      !mf_pin_o[`DPM_IDX_PRA] && !mf_pin_o[`DPM_IDX_PRB])
    else $error("node value visible after lock");
  AST_GCLK_BUF: assert property (@(posedge ref_clk) disable iff (srst)
    !gclk_as_io |=> gclk_buf == $past(gclk_s2_q) && !gclk_pin_oe)
    else $error("global clock buffer path wrong");
  AST_PAD_OUT: assert property (@(posedge ref_clk) disable iff (srst)
    io_ctl[1].cfg == PAD_OUTPUT |=> io_pin_oe[1])
    else $error("output pad not driven");

  COV_FRAME: cover property (@(posedge ref_clk) disable iff (srst) frame_done);
  COV_LOCK:  cover property (@(posedge ref_clk) disable iff (srst) $rose(lock_q));
  COV_DUAL:  cover property (@(posedge ref_clk) disable iff (srst)
    probe_live && sel_a_q != sel_b_q);

endmodule

//--- test/dpm_diag_equip.sv
// Behavioural model of the outside probe and programming equipment.
// Assumes one ref_clk domain and a frame of lock, select B, select A, MSB first.
module dpm_diag_equip #(
  parameter int unsigned SELW = 4
) (
  // Clock
  input  wire logic ref_clk,
  // Lines towards the device
  output logic      mode_pin,
  output logic      diag_clk,
  output logic      diag_data
);
  timeunit 1ns;
  timeprecision 100ps;

  // The pull-down keeps the mode line low until probing is wanted.
  initial begin
    mode_pin  = 1'h0;
    diag_clk  = 1'h0;
    diag_data = 1'h0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic set_mode(input logic m);
    @(posedge ref_clk);
    mode_pin <= m;
  endtask

  // Each low phase lasts four ref_clk cycles and each high phase five, above the two the synchroniser needs.
  task automatic send_frame(input logic lock, input logic [SELW-1:0] sb,
                            input logic [SELW-1:0] sa);
    logic [2*SELW:0] bits;
    bits = {lock, sb, sa};
    for (int i = 2 * SELW; i >= 0; i--) begin
      @(posedge ref_clk);
      diag_clk  <= 1'h0;
      diag_data <= bits[i];
      step(4);
      diag_clk <= 1'h1;
      step(4);
    end
    @(posedge ref_clk);
    diag_clk  <= 1'h0;
    diag_data <= ~diag_data;
  endtask
endmodule

//--- test/dpm_pin_mux_test.sv
// Self-checking bench for the diagnostic probe pin multiplexer.
// Assumes dpm_pkg and dpm_diag_equip are compiled first.
module dpm_pin_mux_test
  import dpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk = 1'h0, srst = 1'h1, gclk_as_io = 1'h0, probe_fuse = 1'h0, gclk_ext = 1'h0;
  logic mode_pin, diag_clk, diag_data, gclk_pin_o, gclk_pin_oe, gclk_user_in, gclk_buf;
  logic probe_locked, diag_active, gclk_pin_i;
  logic [3:0] mf_pin_i, mf_pin_o, mf_pin_oe, mf_user_in;
  logic [7:0] io_pin_i, io_pin_o, io_pin_oe, io_user_in, io_ext = 8'h1d;
  logic [15:0] node_in = 16'h0000;
  dpm_pad_ctl_t [3:0] mf_ctl = '0;
  dpm_pad_ctl_t [7:0] io_ctl = '0;
  dpm_pad_ctl_t gclk_ctl = '0;
  int n_mismatch = 0, checked = 0;

  always #25 ref_clk = ~ref_clk;
  // An undriven probe pad shows the inverse of its last value, not a settled guess.
  assign mf_pin_i = (mf_pin_oe & mf_pin_o) |
                    (~mf_pin_oe & {~mf_pin_o[3:2], diag_data, diag_clk});
  assign io_pin_i = (io_pin_oe & io_pin_o) | (~io_pin_oe & io_ext);
  assign gclk_pin_i = gclk_pin_oe ? gclk_pin_o : gclk_ext;

  dpm_diag_equip #(.SELW(4)) partner_u (.ref_clk(ref_clk), .mode_pin(mode_pin),
    .diag_clk(diag_clk), .diag_data(diag_data));
  dpm_pin_mux #(.IO_PINS(8), .NODES(16)) dut_u (.ref_clk(ref_clk), .srst(srst),
    .mode_pin(mode_pin), .mf_pin_i(mf_pin_i), .mf_pin_o(mf_pin_o), .mf_pin_oe(mf_pin_oe),
    .io_pin_i(io_pin_i), .io_pin_o(io_pin_o), .io_pin_oe(io_pin_oe), .gclk_pin_i(gclk_pin_i),
    .gclk_pin_o(gclk_pin_o), .gclk_pin_oe(gclk_pin_oe), .mf_ctl(mf_ctl),
    .mf_user_in(mf_user_in), .io_ctl(io_ctl), .io_user_in(io_user_in),
    .gclk_as_io(gclk_as_io), .gclk_ctl(gclk_ctl), .gclk_user_in(gclk_user_in),
    .gclk_buf(gclk_buf), .node_in(node_in), .probe_fuse(probe_fuse),
    .probe_locked(probe_locked), .diag_active(diag_active));

  // Waits a number of edges, then lets that edge's updates land.
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_user_pads;
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) mf_ctl[i] <= '{PAD_OUTPUT, i[0], 1'h0};
    for (int i = 0; i < 8; i++) io_ctl[i] <= '{dpm_pad_cfg_t'(i[1:0]), ~i[0], i[2]};
    gclk_as_io <= 1'h1;
    gclk_ctl   <= '{PAD_OUTPUT, 1'h1, 1'h0};
    cyc(5);
    chk("mf_oe", mf_pin_oe, 4'hf);
    chk("mf_o", mf_pin_o, 4'ha);
    chk("diag_act", diag_active, 1'h0);
    chk("io_oe", io_pin_oe, 8'he2);
    chk("io_o", io_pin_o & io_pin_oe, 8'h40);
    chk("io_in", io_user_in, 8'h5d);
    chk("mf_in", mf_user_in, 4'ha);
    chk("gclk_io", {gclk_pin_oe, gclk_pin_o, gclk_user_in, gclk_buf}, 4'he);
    @(posedge ref_clk);
    gclk_as_io <= 1'h0;
    gclk_ext   <= 1'h1;
    mf_ctl[1]  <= '{PAD_TRI, 1'h1, 1'h0};
    io_ext     <= 8'h0c;
    cyc(5);
    chk("gclk_buf_hi", {gclk_pin_oe, gclk_buf, gclk_user_in}, 3'h2);
    chk("mf_tri_oe", mf_pin_oe, 4'hd);
    chk("mf_tri_in", mf_user_in, 4'h8);
    chk("io_in2", io_user_in, 8'h4c);
    @(posedge ref_clk);
    gclk_ext <= 1'h0;
    cyc(5);
    chk("gclk_buf_lo", gclk_buf, 1'h0);
    $display("test user pads done");
  endtask

  task automatic t_probe;
    partner_u.set_mode(1'h1);
    node_in <= 16'h0420;
    cyc(4);
    chk("diag_act", diag_active, 1'h1);
    chk("diag_in_oe", mf_pin_oe[1:0], 2'h0);
    chk("mf_user", mf_user_in, 4'h0);
    partner_u.send_frame(1'h0, 4'h5, 4'ha);
    cyc(6);
    chk("probe_oe", mf_pin_oe[3:2], 2'h3);
    chk("probe_both", mf_pin_o[3:2], 2'h3);
    @(posedge ref_clk);
    node_in <= 16'h0400;
    cyc(3);
    chk("probe_indep", mf_pin_o[3:2], 2'h1);
    partner_u.send_frame(1'h0, 4'ha, 4'h5);
    cyc(6);
    chk("probe_swap", mf_pin_o[3:2], 2'h2);
    $display("test probe done");
  endtask

  task automatic t_lock;
    @(posedge ref_clk);
    node_in <= 16'hffff;
    partner_u.send_frame(1'h1, 4'h1, 4'h2);
    cyc(6);
    chk("locked", probe_locked, 1'h1);
    chk("lock_pins", {mf_pin_oe[3:2], mf_pin_o[3:2]}, 4'h0);
    partner_u.send_frame(1'h0, 4'h1, 4'h2);
    cyc(6);
    chk("still_locked", {mf_pin_oe[3:2], mf_pin_o[3:2]}, 4'h0);
    partner_u.set_mode(1'h0);
    cyc(4);
    chk("back_user", mf_pin_oe, 4'hd);
    @(posedge ref_clk);
    srst       <= 1'h1;
    probe_fuse <= 1'h1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'h0;
    partner_u.set_mode(1'h1);
    cyc(4);
    partner_u.send_frame(1'h0, 4'h3, 4'h4);
    cyc(6);
    chk("fuse", {probe_locked, mf_pin_oe[3:2], mf_pin_o[3:2]}, 5'h10);
    $display("test lock done");
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'h0;
    cyc(2);
    t_user_pads();
    t_probe();
    t_lock();
    give_verdict();
  end

  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end
endmodule
